// ---- logic/cpei_event_regs.sv ----
// Purpose: Event enable and latched event status registers with interrupt
// Assumes: One clock; register strobes and line indications are synchronous
// Notes:   Status clears on read; an event in the read cycle survives it
//          Software reset clears status but keeps the enable word
//          Read data and valid come one edge after the read strobe
//          The interrupt trails status and enable by one more edge
//          Level watchers ignore the first edge after hardware reset,
//          so a level that differs from its reset value is not an event
//
// Contract
// - Enable 1 passes flag, 0 blocks it
// - Enable bits 15,14,13: negotiation error, speed, duplex
// - Enable bits 12,11,10: page, negotiation done, link
// - Enable bits 9,8,6: symbol, false carrier, crossover
// - Enable bits 5,4,3: downshift, energy, pulses-no-link
// - Status/enable bit 1 polarity, bit 0 jabber
// - Status 15 on any negotiation fault cause
// - Status 14 speed change, 13 duplex change
// - Status 12 page received, 11 negotiation done
// - Status 10 on link change either way
// - Status 9 symbol error, 8 false carrier
// - Status 6 crossover change, 5 downshift
// - Status 4 on energy change either way
// - Status 3 pulse exchange done, no link
// - Status bit 7 always reads zero
`default_nettype none

module cpei_event_regs (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sw_reset_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire cpei_pkg::cpei_line_t line_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic irq_o
);

    // Shared bit map of enable and status words:
    //   bit 15 negotiation error (any fault cause)
    //   bit 14 speed change
    //   bit 13 duplex change
    //   bit 12 page received
    //   bit 11 negotiation done
    //   bit 10 link change
    //   bit 9  symbol error
    //   bit 8  false carrier
    //   bit 7  reserved, status reads zero
    //   bit 6  crossover change
    //   bit 5  downshift
    //   bit 4  energy detect change
    //   bit 3  pulse exchange done, no link
    //   bit 2  reserved, status reads zero
    //   bit 1  polarity change
    //   bit 0  jabber
    // Enable bits 7 and 2 keep what is written; they never gate
    // anything because their status bits never latch.

    // Level watchers need one sample before a change can mean anything
    typedef enum logic {
        CPEI_ST_PRIME = 1'b0,
        CPEI_ST_RUN = 1'b1
    } cpei_state_t;

    cpei_state_t state;
    cpei_state_t next_state;
    cpei_pkg::cpei_levels_t levels_prev;
    cpei_pkg::cpei_levels_t next_levels_prev;
    cpei_pkg::cpei_levels_t levels_now;
    logic [15:0] event_enable;
    logic [15:0] next_event_enable;
    logic [15:0] event_status;
    logic [15:0] next_event_status;
    logic [15:0] event_set;
    logic [15:0] next_reg_rdata;
    logic next_reg_rvalid;
    logic next_irq;
    logic watch_levels;
    logic enable_write;
    logic status_read;

    // True when a strobe addresses the given register
    function automatic logic addr_hit(input logic [4:0] addr,
                                      input logic [4:0] target);
        addr_hit = (addr == target);
    endfunction

    // Change detector for a level field, quiet until primed
    function automatic logic changed(input logic [1:0] now_val,
                                     input logic [1:0] old_val,
                                     input logic armed);
        changed = armed && (now_val != old_val);
    endfunction

    // Register strobes decoded once; writes to the status address and
    // accesses to any other address fall through with no effect
    assign enable_write = reg_wr_i
        && addr_hit(reg_addr_i, cpei_pkg::ADDR_EVENT_ENABLE);
    assign status_read = reg_rd_i
        && addr_hit(reg_addr_i, cpei_pkg::ADDR_EVENT_STATUS);

    // Gather the level indications into one word.
    // Keeping them in one struct lets a single register hold the
    // previous sample of every watched level.
    always_comb begin
        levels_now.speed = line_i.speed;
        levels_now.duplex_full = line_i.duplex_full;
        levels_now.link_up = line_i.link_up;
        levels_now.mdix = line_i.mdix;
        levels_now.energy_sleep = line_i.energy_sleep;
        levels_now.polarity_rev = line_i.polarity_rev;
    end

    // Priming state: first cycle after reset only samples the levels.
    // Without it, a level that already differs from its reset value
    // would raise a false change flag on the first edge.
    // Software reset leaves the watcher running on purpose: the
    // levels are still valid then, so no change may be missed.
    always_comb begin
        next_state = state;
        case (state)
            CPEI_ST_PRIME: begin
                next_state = CPEI_ST_RUN;
            end
            CPEI_ST_RUN: begin
                next_state = CPEI_ST_RUN;
            end
            default: begin
                next_state = CPEI_ST_PRIME;
            end
        endcase
        if (reset_i) begin
            next_state = CPEI_ST_PRIME;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        state <= next_state;
    end

    assign watch_levels = (state == CPEI_ST_RUN);

    // Previous levels, kept for change detection
    always_comb begin
        next_levels_prev = levels_now;
        if (reset_i) begin
            next_levels_prev = cpei_pkg::LEVELS_RESET;
        end
    end

    // Previous level register
    always_ff @(posedge sys_clk_i) begin
        levels_prev <= next_levels_prev;
    end

    // Event decode: pulses pass straight, levels are edge-compared
    always_comb begin
        event_set = 16'h0000;
        // Any of the four negotiation fault causes
        event_set[cpei_pkg::BIT_AN_ERROR] = line_i.ms_fault_p
            | line_i.pd_fault_p
            | line_i.no_common_ability_p
            | line_i.link_fail_after_an_p;
        // Any change of the two-bit resolved speed
        event_set[cpei_pkg::BIT_SPEED_CHG] = changed(levels_now.speed,
            levels_prev.speed, watch_levels);
        // Resolved duplex toggled
        event_set[cpei_pkg::BIT_DUPLEX_CHG] = changed(
            {1'b0, levels_now.duplex_full},
            {1'b0, levels_prev.duplex_full}, watch_levels);
        // Partner page arrived
        event_set[cpei_pkg::BIT_PAGE_RX] = line_i.page_rx_p;
        // Negotiation finished
        event_set[cpei_pkg::BIT_AN_DONE] = line_i.an_done_p;
        // Link went up or down
        event_set[cpei_pkg::BIT_LINK_CHG] = changed(
            {1'b0, levels_now.link_up},
            {1'b0, levels_prev.link_up}, watch_levels);
        // Symbol error on the line
        event_set[cpei_pkg::BIT_SYMBOL_ERR] = line_i.symbol_err_p;
        // Carrier seen without a valid frame start
        event_set[cpei_pkg::BIT_FALSE_CARRIER] =
            line_i.false_carrier_p;
        // Crossover state toggled
        event_set[cpei_pkg::BIT_XOVER_CHG] = changed(
            {1'b0, levels_now.mdix},
            {1'b0, levels_prev.mdix}, watch_levels);
        // Speed downshift
        event_set[cpei_pkg::BIT_DOWNSHIFT] = line_i.downshift_p;
        // Energy detect went sleep to active or back
        event_set[cpei_pkg::BIT_ENERGY_CHG] = changed(
            {1'b0, levels_now.energy_sleep},
            {1'b0, levels_prev.energy_sleep}, watch_levels);
        // Pulse exchange done but no link followed
        event_set[cpei_pkg::BIT_PULSE_NO_LINK] =
            line_i.pulse_done_no_link_p;
        // Receive polarity toggled
        event_set[cpei_pkg::BIT_POLARITY_CHG] = changed(
            {1'b0, levels_now.polarity_rev},
            {1'b0, levels_prev.polarity_rev}, watch_levels);
        // Jabber seen
        event_set[cpei_pkg::BIT_JABBER] = line_i.jabber_p;
    end

    // Enable register: all bits writable; software reset retains it.
    // Reserved bits 7 and 2 store whatever is written but gate nothing,
    // since the matching status bits never latch.
    always_comb begin
        next_event_enable = event_enable;
        if (enable_write) begin
            next_event_enable = reg_wdata_i;
        end
        if (reset_i) begin
            next_event_enable = cpei_pkg::EVENT_ENABLE_RESET;
        end
    end

    // Enable register
    always_ff @(posedge sys_clk_i) begin
        event_enable <= next_event_enable;
    end

    // Status register: sticky flags, cleared by a read of the register.
    // A new event in the read cycle wins over the clear, so it is seen
    // on the next read instead of being lost.
    always_comb begin
        next_event_status = event_status;
        if (status_read) begin
            next_event_status = 16'h0000;
        end
        next_event_status = (next_event_status | event_set)
            & cpei_pkg::STATUS_IMPL_MASK;
        if (reset_i || sw_reset_i) begin
            next_event_status = cpei_pkg::EVENT_STATUS_RESET;
        end
    end

    // Status register
    always_ff @(posedge sys_clk_i) begin
        event_status <= next_event_status;
    end

    // Read port: data is the value before any clear of the same cycle.
    // Unknown addresses still answer, with zero data, so the master
    // never waits on a read that nobody owns.
    // Data is forced to zero between reads to keep the bus quiet.
    always_comb begin
        next_reg_rdata = cpei_pkg::READ_IDLE;
        next_reg_rvalid = reg_rd_i;
        if (reg_rd_i) begin
            if (addr_hit(reg_addr_i, cpei_pkg::ADDR_EVENT_ENABLE)) begin
                next_reg_rdata = event_enable;
            end else if (addr_hit(reg_addr_i,
                                  cpei_pkg::ADDR_EVENT_STATUS)) begin
                next_reg_rdata = event_status
                    & cpei_pkg::STATUS_IMPL_MASK;
            end else begin
                next_reg_rdata = cpei_pkg::READ_IDLE;
            end
        end
        if (reset_i) begin
            next_reg_rdata = cpei_pkg::READ_IDLE;
            next_reg_rvalid = 1'b0;
        end
    end

    // Read data and valid registers
    always_ff @(posedge sys_clk_i) begin
        reg_rdata_o <= next_reg_rdata;
        reg_rvalid_o <= next_reg_rvalid;
    end

    // Interrupt: any latched flag with its enable set. Registered from
    // the current flops, so it follows status and enable one edge later.
    // The extra edge buys a glitch-free output straight from a flop.
    // Clearing an enable bit drops the interrupt without losing the
    // flag, so software can still read what happened.
    always_comb begin
        next_irq = |(event_status & event_enable);
        // Per-bit gating places follow the shared bit map
        if (reset_i) begin
            next_irq = 1'b0;
        end
    end

    // Interrupt register
    always_ff @(posedge sys_clk_i) begin
        irq_o <= next_irq;
    end

endmodule

`default_nettype wire

// ---- logic/cpei_pkg.sv ----
// Purpose: Constants and carrier types for the copper event interrupt regs
// Assumes: Management access arrives already decoded to register strobes
// Notes:   Offsets are the five-bit management register addresses
`default_nettype none

package cpei_pkg;

    // Register addresses on the management port
    localparam logic [4:0] ADDR_EVENT_ENABLE = 5'h12;
    localparam logic [4:0] ADDR_EVENT_STATUS = 5'h13;

    // Values after hardware reset
    localparam logic [15:0] EVENT_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] EVENT_STATUS_RESET = 16'h0000;
    localparam logic [15:0] READ_IDLE = 16'h0000;

    // Status bits 7 and 2 never latch
    localparam logic [15:0] STATUS_IMPL_MASK = 16'hFF7B;

    // Bit positions shared by enable and status
    localparam int BIT_AN_ERROR = 15;
    localparam int BIT_SPEED_CHG = 14;
    localparam int BIT_DUPLEX_CHG = 13;
    localparam int BIT_PAGE_RX = 12;
    localparam int BIT_AN_DONE = 11;
    localparam int BIT_LINK_CHG = 10;
    localparam int BIT_SYMBOL_ERR = 9;
    localparam int BIT_FALSE_CARRIER = 8;
    localparam int BIT_RESERVED_HI = 7;
    localparam int BIT_XOVER_CHG = 6;
    localparam int BIT_DOWNSHIFT = 5;
    localparam int BIT_ENERGY_CHG = 4;
    localparam int BIT_PULSE_NO_LINK = 3;
    localparam int BIT_RESERVED_LO = 2;
    localparam int BIT_POLARITY_CHG = 1;
    localparam int BIT_JABBER = 0;

    // Indications from the line logic; *_p are one-cycle pulses
    typedef struct packed {
        logic ms_fault_p;
        logic pd_fault_p;
        logic no_common_ability_p;
        logic link_fail_after_an_p;
        logic [1:0] speed;
        logic duplex_full;
        logic page_rx_p;
        logic an_done_p;
        logic link_up;
        logic symbol_err_p;
        logic false_carrier_p;
        logic mdix;
        logic downshift_p;
        logic energy_sleep;
        logic pulse_done_no_link_p;
        logic polarity_rev;
        logic jabber_p;
    } cpei_line_t;

    // Level indications watched for changes
    typedef struct packed {
        logic [1:0] speed;
        logic duplex_full;
        logic link_up;
        logic mdix;
        logic energy_sleep;
        logic polarity_rev;
    } cpei_levels_t;

    localparam cpei_levels_t LEVELS_RESET = '0;

endpackage

`default_nettype wire

// ---- test/cpei_event_regs_props.sv ----
// Purpose: Port checks for the event enable and status registers
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only the top ports; attached by the bind at the foot
`default_nettype none

module cpei_chk (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sw_reset_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire cpei_pkg::cpei_line_t line_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Decoded requests; the first edge after reset only primes levels
    logic rd_st, rd_en, wr_en;
    assign rd_st = reg_rd_i && reg_addr_i == 5'h13;
    assign rd_en = reg_rd_i && reg_addr_i == 5'h12;
    assign wr_en = reg_wr_i && reg_addr_i == 5'h12;

    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_idle_quiet: assert property (!reg_rd_i |=>
        !reg_rvalid_o && reg_rdata_o == 16'h0000) else $error("stray data");
    a_reserved_zero: assert property (rd_st |=>
        !reg_rdata_o[7] && !reg_rdata_o[2]) else $error("reserved bit set");
    a_enable_back: assert property (wr_en ##1 rd_en && !reg_wr_i |=>
        reg_rdata_o == $past(reg_wdata_i, 2)) else $error("enable lost");
    a_link_flag: assert property (!sw_reset_i && !$past(reset_i) &&
        $changed(line_i.link_up) ##1 rd_st && !sw_reset_i |=> reg_rdata_o[10])
        else $error("link change not latched");
    a_jabber_flag: assert property (line_i.jabber_p && !sw_reset_i
        ##1 rd_st && !sw_reset_i |=> reg_rdata_o[0]) else $error("no jabber");
    a_sw_clear: assert property (sw_reset_i ##1 rd_st |=>
        reg_rdata_o == 16'h0000) else $error("status kept over reset");
    a_reset_quiet: assert property ($past(reset_i) |->
        !irq_o && !reg_rvalid_o) else $error("active after reset");
    a_irq_blocked: assert property (wr_en && reg_wdata_i == 16'h0000
        ##1 !wr_en |=> !irq_o) else $error("irq with no enable");

    c_irq_read: cover property (irq_o && rd_st);
    c_sw_clear: cover property (sw_reset_i ##1 rd_st);
    c_irq_rise: cover property ($rose(irq_o));
endmodule

bind cpei_event_regs cpei_chk i_cpei_chk (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .sw_reset_i(sw_reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .line_i(line_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .irq_o(irq_o));

`default_nettype wire

// ---- test/cpei_line_model.sv ----
// Purpose: Line-side source of PHY events for the register test
// Assumes: One event code per go strobe; codes follow status bits
// Notes: Codes 15 to 18 are the four negotiation fault causes
`default_nettype none

module cpei_line_model (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [4:0] ev_i,
    output var cpei_pkg::cpei_line_t line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [18:0] pul = '0;
    cpei_pkg::cpei_levels_t lv = cpei_pkg::LEVELS_RESET;

    // Pulses last one cycle; levels toggle, speed steps by one, so each call is a change
    always @(posedge sys_clk_i) begin
        pul <= go_i ? 19'h00001 << ev_i : 19'h00000;
        if (go_i) begin
            case (ev_i)
                5'h0E: lv.speed <= lv.speed + 2'h1;
                5'h0D: lv.duplex_full <= ~lv.duplex_full;
                5'h0A: lv.link_up <= ~lv.link_up;
                5'h06: lv.mdix <= ~lv.mdix;
                5'h04: lv.energy_sleep <= ~lv.energy_sleep;
                5'h01: lv.polarity_rev <= ~lv.polarity_rev;
                default: ;
            endcase
        end
    end

    // Pack in field order of the line carrier
    assign line_o = {pul[15], pul[16], pul[17], pul[18], lv.speed,
        lv.duplex_full, pul[12], pul[11], lv.link_up, pul[9], pul[8],
        lv.mdix, pul[5], lv.energy_sleep, pul[3], lv.polarity_rev, pul[0]};
endmodule

`default_nettype wire

// ---- test/test_cpei_event_regs.sv ----
// Purpose: Register level test of the event interrupt registers
// Assumes: Line events come from the line model, one per call
// Notes: Waits follow the one-cycle status and irq stages
`default_nettype none

module test_cpei_event_regs;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
        n_errors++; $display("mismatch %s exp %h got %h", n, e, s); end end

    logic sys_clk_i = 1'b0, reset_i = 1'b1, sw_reset_i = 1'b0, go = 1'b0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o, irq_o;
    logic [4:0] reg_addr_i = 5'h00, ev = 5'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, m;
    cpei_pkg::cpei_line_t line_i;
    int n_errors = 0, n_checks = 0;
    int codes[17] = '{15, 16, 17, 18, 14, 13, 12, 11, 10, 9, 8, 6, 5,
        4, 3, 1, 0};

    // 10 MHz clock
    initial forever #50 sys_clk_i = ~sys_clk_i;

    cpei_event_regs i_cpei_event_regs (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .sw_reset_i(sw_reset_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .line_i(line_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .irq_o(irq_o));
    cpei_line_model i_cpei_line_model (.sys_clk_i(sys_clk_i), .go_i(go),
        .ev_i(ev), .line_o(line_i));

    // Tasks start and end just after a rising edge
    task wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK("rvalid", 1'b1, reg_rvalid_o)
        `CHK("rdata", e, reg_rdata_o)
        @(posedge sys_clk_i);
    endtask

    task evt(input logic [4:0] c);
        ev <= c;
        go <= 1'b1;
        @(posedge sys_clk_i);
        go <= 1'b0;
    endtask

    // Three edges cover the status and irq stages, with one to spare
    task irq_is(input logic e);
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        `CHK("irq", e, irq_o)
        @(posedge sys_clk_i);
    endtask

    task results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_errors++;
        results();
    end

    // Every event: blocked, passed, read-cleared, then read at once
    initial begin
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(5'h12, 16'h0000);
        rd(5'h13, 16'h0000);
        rd(5'h05, 16'h0000);
        wr(5'h12, 16'hFF7B);
        rd(5'h12, 16'hFF7B);
        foreach (codes[i]) begin
            m = 16'h0001 << (codes[i] > 14 ? 15 : codes[i]);
            wr(5'h12, 16'hFF7B & ~m);
            evt(5'(codes[i]));
            irq_is(1'b0);
            wr(5'h12, m);
            irq_is(1'b1);
            rd(5'h13, m);
            irq_is(1'b0);
            rd(5'h13, 16'h0000);
            evt(5'(codes[i]));
            @(posedge sys_clk_i);
            rd(5'h13, m);
        end
        wr(5'h12, 16'hFF7B);
        evt(5'h09);
        irq_is(1'b1);
        sw_reset_i <= 1'b1;
        @(posedge sys_clk_i);
        sw_reset_i <= 1'b0;
        rd(5'h13, 16'h0000);
        rd(5'h12, 16'hFF7B);
        wr(5'h12, 16'h0000);
        irq_is(1'b0);
        results();
    end
endmodule

`default_nettype wire
